/* File: hdl/eps_pkg.sv */
// Constants, types and timing figures shared by the eye pattern serializer.
// Assumes a single 200 MHz system clock; no software-visible registers.
//
// Notes on behaviour
// - Every eye sample leaves the device as exactly sixteen serial data bits.
// - The X coordinate byte goes out first, then the Y coordinate byte.
// - Inside each byte the least significant bit goes out first by default.
// - The data line advances one bit on each rising edge of the 1.536 MHz shift clock.
// - The data line is meaningful only while the frame strobe is low; the receiver ignores it otherwise.
// - The frame strobe changes level only together with a rising edge of the shift clock.
package eps_pkg;

   // Clock rates in kHz, as specified
   localparam int SYS_CLK_KHZ = 200000;
   localparam int EYE_CLK_KHZ = 1536;
   // Half period of the shift clock in system cycles, rounded down
   localparam int EYE_HALF_CYC_INT = SYS_CLK_KHZ / (2 * EYE_CLK_KHZ);
   localparam int DIV_W = 7;
   localparam logic [DIV_W-1:0] EYE_HALF_CYC = EYE_HALF_CYC_INT[DIV_W-1:0];
   localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;
   localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;

   // Word layout: X in the low byte, Y in the high byte
   localparam int BYTE_W = 8;
   localparam int WORD_W = 16;
   localparam int X_LSB = 0;
   localparam int Y_LSB = 8;

   // Bit counter within one frame
   localparam int BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 5'h00;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 5'h01;
   localparam logic [BIT_CNT_W-1:0] BITS_PER_WORD = 5'h10;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h0F;

   // Sample buffer
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_AW = 2;

   // Shifter states
   typedef enum logic [0:0] {
      EPS_IDLE = 1'b0,
      EPS_SHIFT = 1'b1
   } eps_state_t;

endpackage

/* File: hdl/eps_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/10ps
`default_nettype none
module eps_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic clk_i, // System clock
   input wire logic rstn_i, // Synchronised reset, active low
   input wire logic [WIDTH-1:0] in_data_i, // Write data
   input wire logic in_valid_i, // Write request
   output logic in_ready_o, // Room available
   output logic [WIDTH-1:0] out_data_o, // Head entry
   output logic out_valid_o, // Head valid
   input wire logic out_ready_i // Head consumed
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire logic push;
   wire logic pop;

   // Handshakes; full and empty come straight from the occupancy
   assign in_ready_o = (count != DEPTH[AW:0]);
   assign out_valid_o = (count != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem[rd_ptr];

   // Storage; no reset needed on the data array
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers wrap naturally since the depth is a power of two
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // eps_fifo
`default_nettype wire

/* File: hdl/eps_clkdiv.sv */
// Divider making the free-running eye shift clock from the system clock.
// Assumes the synchronised reset; rise_o marks the cycle before the clock goes high.
`timescale 1ns/10ps
`default_nettype none
module eps_clkdiv (
   input wire logic clk_i, // System clock
   input wire logic rstn_i, // Synchronised reset, active low
   output logic shift_clk_o, // Divided shift clock
   output logic rise_o // Pulse: shift clock rises at next edge
);
   import eps_pkg::*;

   logic [DIV_W-1:0] cnt;
   logic clk_q;
   wire logic wrap;

   // Toggle every half period; the enable lets the shifter move in step
   assign wrap = (cnt == EYE_HALF_CYC - DIV_ONE);
   assign rise_o = wrap & ~clk_q;
   assign shift_clk_o = clk_q;

   // Counter and clock flop
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= DIV_ZERO;
         clk_q <= 1'b0;
      end else begin
         cnt <= wrap ? DIV_ZERO : cnt + DIV_ONE;
         clk_q <= wrap ? ~clk_q : clk_q;
      end
   end
endmodule // eps_clkdiv
`default_nettype wire

/* File: hdl/eps_serializer.sv */
// Eye pattern serializer: buffers X/Y samples and shifts each out as a
// sixteen bit framed word on the eye data pin.
// Assumes samples arrive on the system clock; the shift clock is made here.
// The far end is expected to take each bit on the falling shift clock edge.
`timescale 1ns/10ps
`default_nettype none
module eps_serializer #(
   parameter bit LSB_FIRST = 1'b1 // Bit order inside each byte
) (
   input wire logic clk_i, // System clock, 200 MHz
   input wire logic rstn_i, // Asynchronous reset, active low
   input wire logic [eps_pkg::BYTE_W-1:0] sample_x_i, // X coordinate
   input wire logic [eps_pkg::BYTE_W-1:0] sample_y_i, // Y coordinate
   input wire logic sample_valid_i, // Sample offered
   output logic sample_ready_o, // Buffer has room
   output logic eye_data_o, // Serial eye data
   output logic eye_shift_clock_o, // Free-running shift clock
   output logic eye_frame_strobe_n_o // Frame strobe, active low
);
   import eps_pkg::*;

   // Reset synchroniser
   logic rst_meta_n;
   logic rst_n;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // Sample word: X low byte, Y high byte
   wire logic [WORD_W-1:0] in_word;
   assign in_word = {sample_y_i, sample_x_i};

   wire logic [WORD_W-1:0] head_word;
   wire logic head_valid;
   wire logic head_pop;

   // Four-entry buffer absorbs bursts while a frame is on the wire
   eps_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk_i(clk_i),
      .rstn_i(rst_n),
      .in_data_i(in_word),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .out_data_o(head_word),
      .out_valid_o(head_valid),
      .out_ready_i(head_pop)
   );

   wire logic shift_rise;
   wire logic shift_clk;

   // Shift clock source; it runs whether or not a frame is pending
   eps_clkdiv u_div (
      .clk_i(clk_i),
      .rstn_i(rst_n),
      .shift_clk_o(shift_clk),
      .rise_o(shift_rise)
   );

   // Reorder bits so the shifter always drains from bit zero
   wire logic [WORD_W-1:0] order_word;
   genvar gi;
   generate
      for (gi = 0; gi < BYTE_W; gi++) begin : g_order
         assign order_word[X_LSB+gi] = LSB_FIRST ? head_word[X_LSB+gi]
                                                 : head_word[X_LSB+BYTE_W-1-gi];
         assign order_word[Y_LSB+gi] = LSB_FIRST ? head_word[Y_LSB+gi]
                                                 : head_word[Y_LSB+BYTE_W-1-gi];
      end
   endgenerate

   eps_state_t state;
   eps_state_t next_state;
   logic [WORD_W-1:0] shreg;
   logic [BIT_CNT_W-1:0] bit_cnt;
   logic data_q;
   logic strobe_n_q;

   // Decode of the shift steps; all moves happen on a shift clock rise
   wire logic start_frame;
   wire logic last_bit;
   wire logic step_bit;
   wire logic end_frame;
   assign start_frame = shift_rise & (state == EPS_IDLE) & head_valid;
   assign last_bit = (bit_cnt == LAST_BIT);
   assign step_bit = shift_rise & (state == EPS_SHIFT) & ~last_bit;
   assign end_frame = shift_rise & (state == EPS_SHIFT) & last_bit;
   assign head_pop = start_frame;

   // Next state; a frame always leaves one strobe-high period before the next
   always_comb begin
      next_state = state;
      case (state)
         EPS_IDLE: begin
            if (start_frame) begin
               next_state = EPS_SHIFT;
            end
         end
         EPS_SHIFT: begin
            if (end_frame) begin
               next_state = EPS_IDLE;
            end
         end
         default: begin
            next_state = EPS_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state <= EPS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Shifter and counter; X byte sits in the low half, so it drains first
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= '0;
         bit_cnt <= BIT_CNT_ZERO;
      end else if (start_frame) begin
         shreg <= order_word >> 1;
         bit_cnt <= BIT_CNT_ZERO;
      end else if (step_bit) begin
         shreg <= shreg >> 1;
         bit_cnt <= bit_cnt + BIT_CNT_ONE;
      end else if (end_frame) begin
         bit_cnt <= BIT_CNT_ZERO;
      end
   end

   // Pin flops; they move only on a rise, so the far end sees clean edges
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         data_q <= 1'b0;
         strobe_n_q <= 1'b1;
      end else if (start_frame) begin
         data_q <= order_word[0];
         strobe_n_q <= 1'b0;
      end else if (step_bit) begin
         data_q <= shreg[0];
      end else if (end_frame) begin
         data_q <= 1'b0;
         strobe_n_q <= 1'b1;
      end
   end

   // Data and strobe change with the clock flop, so the receiver can take
   // each bit on the falling edge half a period later
   assign eye_data_o = data_q;
   assign eye_shift_clock_o = shift_clk;
   assign eye_frame_strobe_n_o = strobe_n_q;

   // ---- Checks ----
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   // Helper: shift clock rises counted while the strobe is low
   logic [BIT_CNT_W-1:0] low_rises;
   logic [DIV_W:0] hi_cnt;
   logic [DIV_W:0] lo_cnt;
   logic [WORD_W-1:0] cur_word;
   logic [BIT_CNT_W-1:0] cur_idx;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         low_rises <= BIT_CNT_ZERO;
         hi_cnt <= '0;
         lo_cnt <= '0;
         cur_word <= '0;
         cur_idx <= BIT_CNT_ZERO;
      end else begin
         if ($rose(eye_shift_clock_o)) begin
            low_rises <= eye_frame_strobe_n_o ? BIT_CNT_ZERO : low_rises + BIT_CNT_ONE;
         end
         hi_cnt <= eye_shift_clock_o ? hi_cnt + 1'b1 : '0;
         lo_cnt <= eye_shift_clock_o ? '0 : lo_cnt + 1'b1;
         if (start_frame) begin
            cur_word <= head_word;
            cur_idx <= BIT_CNT_ZERO;
         end else if (step_bit) begin
            cur_idx <= cur_idx + BIT_CNT_ONE;
         end
      end
   end

   // Expected bit for the current index, from the original sample
   localparam logic [2:0] TOP_BIT_IDX = 3'(BYTE_W - 1);
   wire logic [2:0] bit_in_byte;
   wire logic [2:0] src_bit;
   wire logic expect_bit;
   assign bit_in_byte = cur_idx[2:0];
   assign src_bit = LSB_FIRST ? bit_in_byte : TOP_BIT_IDX - bit_in_byte;
   assign expect_bit = cur_idx[3] ? cur_word[Y_LSB + src_bit] : cur_word[X_LSB + src_bit];

   // A frame ends after exactly sixteen bit periods
   AST_SIXTEEN_BITS: assert property (
      $rose(eye_frame_strobe_n_o) |-> (low_rises == BITS_PER_WORD))
      else $error("frame did not carry sixteen bits");

   // X byte occupies the first eight bits of the frame
   AST_X_FIRST: assert property (
      (!eye_frame_strobe_n_o && state == EPS_SHIFT && !cur_idx[3]) |->
      (eye_data_o == cur_word[X_LSB + src_bit]))
      else $error("X byte bit out of place");

   // Every bit matches the sample in the chosen order
   AST_BIT_ORDER: assert property (
      (state == EPS_SHIFT) |-> (eye_data_o == expect_bit))
      else $error("serial bit does not match sample");

   // Data only moves together with a shift clock rise
   AST_DATA_ON_RISE: assert property (
      $changed(eye_data_o) |-> $rose(eye_shift_clock_o))
      else $error("data changed away from a shift clock rise");

   // Shift clock high phase lasts the half period exactly
   AST_CLK_HALF: assert property (
      $fell(eye_shift_clock_o) |-> ($past(hi_cnt) == {1'b0, EYE_HALF_CYC} - 1'b1))
      else $error("shift clock half period wrong");

   // Data is held low while no frame is on the wire
   AST_IDLE_LOW: assert property (
      eye_frame_strobe_n_o |-> !eye_data_o)
      else $error("data active with strobe high");

   // Strobe only moves together with a shift clock rise
   AST_STB_ON_RISE: assert property (
      $changed(eye_frame_strobe_n_o) |-> $rose(eye_shift_clock_o))
      else $error("strobe changed away from a shift clock rise");

   // Helper: captured candidates for the first bit
   logic head_word_q0;
   logic head_word_q7;
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         head_word_q0 <= 1'b0;
         head_word_q7 <= 1'b0;
      end else if (start_frame) begin
         head_word_q0 <= head_word[X_LSB];
         head_word_q7 <= head_word[X_LSB+BYTE_W-1];
      end
   end

   // First bit follows the byte order parameter
   AST_FIRST_BIT: assert property (
      start_frame |=> (eye_data_o == (LSB_FIRST ? head_word_q0 : head_word_q7)))
      else $error("first bit ignores the order setting");

   // Buffer entry is consumed only at a frame start
   AST_POP_AT_START: assert property (
      head_pop |=> (state == EPS_SHIFT) && !eye_frame_strobe_n_o)
      else $error("buffer popped without a frame");

   // Low phase of the shift clock lasts as long as the high phase
   AST_CLK_LOW: assert property (
      $rose(eye_shift_clock_o) |-> ($past(lo_cnt) == {1'b0, EYE_HALF_CYC} - 1'b1))
      else $error("shift clock low phase wrong");

   // Y byte occupies the last eight bits of the frame
   AST_Y_SECOND: assert property (
      (!eye_frame_strobe_n_o && state == EPS_SHIFT && cur_idx[3]) |->
      (eye_data_o == cur_word[Y_LSB + src_bit]))
      else $error("Y byte bit out of place");

   // Strobe is low for exactly the shifting state
   AST_STB_IN_SHIFT: assert property (
      (state == EPS_SHIFT) == !eye_frame_strobe_n_o)
      else $error("strobe disagrees with the frame state");

   // A finished frame leaves the line idle and low
   AST_END_IDLE: assert property (
      end_frame |=> eye_frame_strobe_n_o && !eye_data_o && state == EPS_IDLE)
      else $error("frame end left the line active");

   // No buffer entry is taken while a frame is on the wire
   AST_NO_POP_MID: assert property (
      (state == EPS_SHIFT) |-> !head_pop)
      else $error("buffer popped during a frame");

   // A waiting sample starts its frame at the first free shift clock rise
   AST_START_PROMPT: assert property (
      (shift_rise && state == EPS_IDLE && head_valid) |=> !eye_frame_strobe_n_o)
      else $error("waiting sample did not start a frame");

   // Bits step only inside a frame
   AST_STEP_IN_FRAME: assert property (
      step_bit |-> !eye_frame_strobe_n_o)
      else $error("bit step outside a frame");

   // The divider's enable pulse really comes just before a shift clock rise
   AST_RISE_PULSE: assert property (
      shift_rise |=> $rose(eye_shift_clock_o))
      else $error("rise pulse not followed by a shift clock rise");
endmodule // eps_serializer
`default_nettype wire

/* File: bench/eps_receiver.sv */
// Far-end model of the eye pattern link: a shift register in front of the DACs.
// Assumes the device drives the shift clock, strobe and data; nothing is driven back.
`timescale 1ns/10ps
`default_nettype none
module eps_receiver (
   input wire logic shift_clk_i, // Shift clock from the device
   input wire logic strobe_n_i, // Frame strobe, active low
   input wire logic data_i, // Serial eye data
   output var logic [15:0] word_o = 16'h0000, // Last frame, first bit in bit 0
   output var logic [4:0] nbits_o = 5'h00, // Bits counted in that frame
   output var int frames_o = 0 // Frames received so far
);
   logic [15:0] sreg = 16'h0000;
   logic [4:0] cnt = 5'h00;
   // Capture on the falling edge, half a period after launch, so setup is ample
   always @(negedge shift_clk_i) begin
      if (!strobe_n_i) begin
         sreg[cnt[3:0]] <= data_i;
         cnt <= cnt + 5'h01;
      end else if (cnt != 5'h00) begin
         word_o <= sreg;
         nbits_o <= cnt;
         cnt <= 5'h00;
         frames_o <= frames_o + 1;
      end
   end
endmodule // eps_receiver
`default_nettype wire

/* File: bench/eps_serializer_test.sv */
// Self-checking bench for the eye pattern serializer, both bit orders side by side.
// Assumes the far-end model in eps_receiver and the package constants.
`timescale 1ns/10ps
`default_nettype none
module eps_serializer_test;
   import eps_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [BYTE_W-1:0] sx = 8'h00;
   logic [BYTE_W-1:0] sy = 8'h00;
   logic sval = 1'b0;
   logic rdy, rdy_m, dat, dat_m, sck, sck_m, stb_n, stb_n_m;
   logic [15:0] word, word_m;
   logic [4:0] nb, nb_m;
   int frames, frames_m;
   logic [15:0] exp_q[$];
   int error_cnt = 0;
   int n_checks = 0;
   int cycles = 0;
   int since = -1000000;
   logic p_sck = 1'b0;
   logic p_stb = 1'b1;
   logic p_dat = 1'b0;
   logic saw_full = 1'b0;

   always #2.5 clk_i = ~clk_i;

   eps_serializer u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .sample_x_i(sx), .sample_y_i(sy),
      .sample_valid_i(sval), .sample_ready_o(rdy), .eye_data_o(dat),
      .eye_shift_clock_o(sck), .eye_frame_strobe_n_o(stb_n));
   eps_serializer #(.LSB_FIRST(1'b0)) u_dut_msb (.clk_i(clk_i), .rstn_i(rstn_i),
      .sample_x_i(sx), .sample_y_i(sy), .sample_valid_i(sval), .sample_ready_o(rdy_m),
      .eye_data_o(dat_m), .eye_shift_clock_o(sck_m), .eye_frame_strobe_n_o(stb_n_m));
   eps_receiver u_rx (.shift_clk_i(sck), .strobe_n_i(stb_n), .data_i(dat),
      .word_o(word), .nbits_o(nb), .frames_o(frames));
   eps_receiver u_rx_msb (.shift_clk_i(sck_m), .strobe_n_i(stb_n_m), .data_i(dat_m),
      .word_o(word_m), .nbits_o(nb_m), .frames_o(frames_m));

   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Expected word of the MSB-first build: each byte reversed
   function automatic logic [15:0] swap(input logic [15:0] w);
      logic [15:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = w[7-i];
         r[8+i] = w[15-i];
      end
      return r;
   endfunction

   // Offer one sample; valid stays up so the next call can follow back to back
   task automatic send(input logic [7:0] x, input logic [7:0] y);
      sx <= x;
      sy <= y;
      sval <= 1'b1;
      exp_q.push_back({y, x});
      @(posedge clk_i);
      while (rdy !== 1'b1) @(posedge clk_i);
   endtask

   task automatic wait_frames(input int k);
      int n;
      n = 0;
      while ((frames < k || frames_m < k) && n < 30000) begin
         @(posedge clk_i);
         n++;
      end
      check_val("frames", k[15:0], frames[15:0]);
      check_val("frames msb", k[15:0], frames_m[15:0]);
   endtask

   // Every finished frame is judged against the queue of offered samples
   always @(frames) begin
      #1; // Let the model's word land before judging it
      if (frames > 0) begin
         check_val("lsb first word", exp_q[frames-1], word);
         check_val("bit count", 16'h0010, {11'h000, nb});
      end
   end
   always @(frames_m) begin
      #1; // Let the model's word land before judging it
      if (frames_m > 0) begin
         check_val("msb first word", swap(exp_q[frames_m-1]), word_m);
         check_val("bit count msb", 16'h0010, {11'h000, nb_m});
      end
   end

   // Wire timing, looked at once the edge's updates have landed
   always @(posedge clk_i) begin
      #1;
      if (stb_n !== p_stb) check_val("strobe at clock rise", 16'h0001, {15'h0000, sck & ~p_sck});
      if (dat !== p_dat) check_val("data at clock rise", 16'h0001, {15'h0000, sck & ~p_sck});
      if (sck && !p_sck) begin
         if (since > 0) check_val("shift period", 2 * EYE_HALF_CYC, since[15:0]);
         since = 0;
      end
      since++;
      if (rdy === 1'b0) saw_full = 1'b1;
      p_sck = sck;
      p_stb = stb_n;
      p_dat = dat;
   end

   // Hang guard: the two sample batches need well under this
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic reset_values();
      check_val("strobe in reset", 16'h0001, {15'h0000, stb_n});
      check_val("ready in reset", 16'h0001, {15'h0000, rdy});
      check_val("data in reset", 16'h0000, {15'h0000, dat});
      check_val("shift clock in reset", 16'h0000, {15'h0000, sck});
   endtask

   // Corner bits of both bytes, so a swapped order or byte cannot hide
   task automatic single_word();
      @(posedge clk_i);
      send(8'h01, 8'h80);
      sval <= 1'b0;
      wait_frames(1);
   endtask

   // Back to back until the buffer refuses, then drain in order
   task automatic burst();
      logic [7:0] pat[6] = '{8'hA5, 8'h3C, 8'hFF, 8'h00, 8'h96, 8'h0F};
      @(posedge clk_i);
      for (int i = 0; i < 6; i++) send(pat[i], ~pat[5-i]);
      sval <= 1'b0;
      check_val("buffer refused", 16'h0001, {15'h0000, saw_full});
      wait_frames(7);
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      reset_values();
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      single_word();
      burst();
      wrap_up();
   end
endmodule // eps_serializer_test
`default_nettype wire
